// ### pkg/sync_pkg.sv
// Purpose: shared constants and types for the sample-sync front end
// Assumes: one clock, the master sample clock, at 100 MHz
// Notes:   all pins of the sync path are active low
//
// Operation
// - each rising edge of the clock pin is one master sample clock edge
// - accept an asynchronous start request, sample it, emit one resync pulse
// - start request is synchronised into the master clock domain first
// - resync output moves only in response to a start request
// - sync input pulse realigns sampling and frame timing
// - periodic frame strobe, synchronous to the shift clock, frames each result set
package sync_pkg;

   // ********************************
   // timing
   // ********************************
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned FRAME_LEN       = 64;   // master clocks per result frame
   localparam int unsigned SHIFT_HALF      = 1;    // master clocks per shift clock half
   localparam int unsigned ALIGN_HOLD      = 4;    // hold count; counters stay cleared ALIGN_HOLD + 1 clocks past the sync edge clock
   localparam int unsigned STROBE_LEN      = 2 * SHIFT_HALF;

   localparam int unsigned FRAME_W = $clog2(FRAME_LEN);
   localparam int unsigned HOLD_W  = $clog2(ALIGN_HOLD + 1);

   localparam logic [FRAME_W-1:0] FRAME_LAST  = FRAME_W'(FRAME_LEN - 1);
   localparam logic [FRAME_W-1:0] FRAME_ZERO  = FRAME_W'(0);
   localparam logic [FRAME_W-1:0] STROBE_END  = FRAME_W'(STROBE_LEN);
   localparam logic [HOLD_W-1:0]  HOLD_LOAD   = HOLD_W'(ALIGN_HOLD);
   localparam logic [HOLD_W-1:0]  HOLD_ZERO   = HOLD_W'(0);
   localparam logic [1:0]         SYNC_CNT_MAX = 2'h2;
   localparam logic [1:0]         SYNC_CNT_ZERO = 2'h0;

   // ********************************
   // idle levels of active-low pins
   // ********************************
   localparam logic PIN_IDLE = 1'h1;

   // ********************************
   // alignment states
   // ********************************
   typedef enum logic [1:0] {
      ALIGN_IDLE = 2'b00,
      ALIGN_HOLDING = 2'b01,
      ALIGN_RUN  = 2'b10
   } align_state_t;

endpackage

// ### pkg/start_evt_if.sv
// Purpose: carries the synchronised start event from the catcher to the core
// Assumes: both ends run on the master sample clock
// Notes:   reqFall is a one-clock pulse
`timescale 1ns/1ps
interface start_evt_if;
   logic reqFall;

   modport catcher (output reqFall);
   modport core    (input reqFall);
endinterface

// ### rtl/start_req_catcher.sv
// Purpose: bring the asynchronous start request into the master clock domain
// Assumes: startReq_n may change at any time relative to sys_clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module start_req_catcher
   import sync_pkg::*;
(
   // clock and reset
   input  wire logic    sys_clk,
   input  wire logic    rst_n,
   // pin
   input  wire logic    startReq_n,
   // event toward core
   start_evt_if.catcher evt
);

   logic meta_reg;
   logic stable_reg;
   logic prev_reg;
   logic fall_reg;

   // ********************************
   // two-stage synchroniser
   // ********************************
   // reset to the idle level so release of reset never looks like a request
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg   <= PIN_IDLE;
         stable_reg <= PIN_IDLE;
      end else begin
         meta_reg   <= startReq_n;
         stable_reg <= meta_reg;
      end
   end

   // ********************************
   // falling-edge detect
   // ********************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_reg <= PIN_IDLE;
         fall_reg <= 1'h0;
      end else begin
         prev_reg <= stable_reg;
         fall_reg <= prev_reg & ~stable_reg;
      end
   end

   assign evt.reqFall  = fall_reg;

endmodule

// ### rtl/multi_adc_sync_pulse_logic.sv
// Purpose: sync front end of a multichannel sampling converter
// Assumes: sys_clk is the master sample clock taken from the clock input pin
// Notes:   resync output must be looped back to syncIn_n outside the device
`timescale 1ns/1ps
module multi_adc_sync_pulse_logic
   import sync_pkg::*;
(
   // master sample clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // asynchronous start request, active low
   input  wire logic startReq_n,
   // sync input, already in the master clock domain, active low
   input  wire logic syncIn_n,
   // resync output, active low
   output logic      syncOut_n,
   // result framing
   output logic      resultShiftClk,
   output logic      resultFrameStrobe,
   output logic      sampleTick,
   // alignment status
   output logic      aligned,
   output logic [1:0] syncCount
);

   // ********************************
   // start request path
   // ********************************
   start_evt_if evt ();

   start_req_catcher u_catcher (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .startReq_n (startReq_n),
      .evt        (evt)
   );

   logic syncOut_reg;

   // the output is low for exactly one clock per caught start edge and
   // never moves otherwise, so a tied-high start leaves it idle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         syncOut_reg <= PIN_IDLE;
      end else begin
         syncOut_reg <= ~evt.reqFall;
      end
   end

   assign syncOut_n = syncOut_reg;

   // ********************************
   // sync input edge
   // ********************************
   // the sync input is master-domain by contract, so one register is
   // enough; a second stage would only add a clock of skew between peers
   logic syncInSamp_reg;
   logic syncInPrev_reg;
   logic syncEdge;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         syncInSamp_reg <= PIN_IDLE;
         syncInPrev_reg <= PIN_IDLE;
      end else begin
         syncInSamp_reg <= syncIn_n;
         syncInPrev_reg <= syncInSamp_reg;
      end
   end

   assign syncEdge = syncInPrev_reg & ~syncInSamp_reg;

   // ********************************
   // alignment state machine
   // ********************************
   align_state_t     state_reg;
   align_state_t     state_next;
   logic [HOLD_W-1:0] hold_reg;
   logic [HOLD_W-1:0] hold_next;

   always_comb begin
      state_next = state_reg;
      hold_next  = hold_reg;
      unique case (state_reg)
         ALIGN_IDLE: begin
            state_next = ALIGN_RUN;
         end
         ALIGN_HOLDING: begin
            if (hold_reg == HOLD_ZERO) begin
               state_next = ALIGN_RUN;
            end else begin
               hold_next = hold_reg - HOLD_W'(1);
            end
         end
         ALIGN_RUN: begin
            state_next = ALIGN_RUN;
         end
         default: begin
            state_next = ALIGN_IDLE;
         end
      endcase
      // a new sync edge restarts the hold from any state
      if (syncEdge) begin
         state_next = ALIGN_HOLDING;
         hold_next  = HOLD_LOAD;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ALIGN_IDLE;
         hold_reg  <= HOLD_ZERO;
      end else begin
         state_reg <= state_next;
         hold_reg  <= hold_next;
      end
   end

   logic running;

   assign running = (state_reg == ALIGN_RUN) && !syncEdge;

   // ********************************
   // sync count status
   // ********************************
   // saturates at two: peers are only trusted aligned after a second pulse
   logic [1:0] syncCnt_reg;
   logic       aligned_reg;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         syncCnt_reg <= SYNC_CNT_ZERO;
      end else if (syncEdge && syncCnt_reg != SYNC_CNT_MAX) begin
         syncCnt_reg <= syncCnt_reg + 2'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aligned_reg <= 1'h0;
      end else begin
         aligned_reg <= (syncCnt_reg == SYNC_CNT_MAX) && (state_reg == ALIGN_RUN);
      end
   end

   assign syncCount = syncCnt_reg;
   assign aligned   = aligned_reg;

   // ********************************
   // frame counter
   // ********************************
   logic [FRAME_W-1:0] frame_reg;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_reg <= FRAME_ZERO;
      end else if (!running) begin
         frame_reg <= FRAME_ZERO;
      end else if (frame_reg == FRAME_LAST) begin
         frame_reg <= FRAME_ZERO;
      end else begin
         frame_reg <= frame_reg + FRAME_W'(1);
      end
   end

   // ********************************
   // shift clock
   // ********************************
   // divided from the master clock and phase-reset on sync so that the
   // strobe and shift clock keep a fixed relation in every device
   logic shiftClk_reg;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         shiftClk_reg <= 1'h0;
      end else if (!running) begin
         shiftClk_reg <= 1'h0;
      end else begin
         shiftClk_reg <= ~shiftClk_reg;
      end
   end

   assign resultShiftClk = shiftClk_reg;

   // ********************************
   // frame strobe and sample tick
   // ********************************
   logic strobe_reg;
   logic tick_reg;

   // strobe covers one full shift clock period at the head of each frame
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         strobe_reg <= 1'h0;
      end else begin
         strobe_reg <= running && (frame_reg < STROBE_END);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_reg <= 1'h0;
      end else begin
         tick_reg <= running && (frame_reg == FRAME_ZERO);
      end
   end

   assign resultFrameStrobe = strobe_reg;
   assign sampleTick        = tick_reg;

endmodule

// ### sim/multi_adc_sync_pulse_logic_props.sv
// Purpose: port assertions for the sync front end
// Assumes: start request held high through reset
// Notes:   bound to the top module
`timescale 1ns/1ps
module multi_adc_sync_pulse_logic_props (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       rst_n,
   // sync path
   input wire logic       startReq_n,
   input wire logic       syncIn_n,
   input wire logic       syncOut_n,
   // framing and status
   input wire logic       resultShiftClk,
   input wire logic       resultFrameStrobe,
   input wire logic       sampleTick,
   input wire logic       aligned,
   input wire logic [1:0] syncCount
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_outOne; $fell(syncOut_n) |=> syncOut_n; endproperty
   a_outOne: assert property (p_outOne) else $error("resync low too long");
   property p_outCause;
      $fell(syncOut_n) |-> !$past(startReq_n, 4) && $past(startReq_n, 5);
   endproperty
   a_outCause: assert property (p_outCause) else $error("resync without start");
   property p_quiet; startReq_n [*6] |-> syncOut_n; endproperty
   a_quiet: assert property (p_quiet) else $error("resync while idle");
   property p_cntOne; $fell(syncIn_n) && syncCount == 2'h0 |-> ##[1:3] syncCount == 2'h1; endproperty
   a_cntOne: assert property (p_cntOne) else $error("sync count stuck");
   property p_alignCnt; aligned |-> syncCount == 2'h2; endproperty
   a_alignCnt: assert property (p_alignCnt) else $error("aligned early");
   property p_strobe;
      // a sync edge right after the frame head legally cuts the strobe short
      $rose(resultFrameStrobe) && $past(syncIn_n) |-> sampleTick
         ##1 (resultFrameStrobe && !sampleTick)
         ##1 !resultFrameStrobe;
   endproperty
   a_strobe: assert property (p_strobe) else $error("frame strobe shape");
   property p_shift; $rose(resultShiftClk) |=> $fell(resultShiftClk); endproperty
   a_shift: assert property (p_shift) else $error("shift clock rate");
   property p_realign;
      $fell(syncIn_n) |-> ##3 !sampleTick [*4] ##[1:2] sampleTick;
   endproperty
   a_realign: assert property (p_realign) else $error("frame not realigned");
   c_out: cover property ($fell(syncOut_n));
   c_aligned: cover property ($rose(aligned));
   c_tick: cover property (aligned && sampleTick);
endmodule
bind multi_adc_sync_pulse_logic multi_adc_sync_pulse_logic_props props_u (.sys_clk, .rst_n,
   .startReq_n, .syncIn_n, .syncOut_n, .resultShiftClk, .resultFrameStrobe, .sampleTick,
   .aligned, .syncCount);

// ### sim/sync_ctrl_model.sv
// Purpose: controller and board wiring around the sync front end
// Assumes: requests are issued at a falling clock edge
// Notes:   skew keeps the start request off the sampling edge
`timescale 1ns/1ps
module sync_ctrl_model (
   // master clock
   input  wire logic sys_clk,
   // board signals
   input  wire logic syncOut_n,
   input  wire logic directSync_n,
   output logic      startReq_n,
   output logic      syncIn_n
);
   // loopback, plus an optional system pulse made in the master domain
   assign syncIn_n = syncOut_n & directSync_n;
   initial startReq_n = 1'h1;
   task automatic request(input int lowCyc, input int skewPs, input int gap);
      #(skewPs / 1000.0);
      startReq_n = 1'h0;
      repeat (lowCyc) @(negedge sys_clk);
      startReq_n = 1'h1;
      repeat (gap) @(negedge sys_clk);
   endtask
endmodule

// ### sim/multi_adc_sync_pulse_logic_tb.sv
// Purpose: self-checking bench for the sync front end
// Assumes: resync output looped back by the partner model
// Notes:   expected latency counts from the last edge before the request
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin nCompared++; if ((got) !== (exp)) begin errCount++; \
   $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); end end
module multi_adc_sync_pulse_logic_tb;
   import sync_pkg::*;
   logic       sys_clk, rst_n, directSync_n, startReq_n, syncIn_n, syncOut_n;
   logic       resultShiftClk, resultFrameStrobe, sampleTick, aligned;
   logic [1:0] syncCount;
   int         errCount, nCompared, cyc, lastTick, lastSync, syncSeen, expCyc;
   int         expQ[$];
   multi_adc_sync_pulse_logic dut_u (.sys_clk, .rst_n, .startReq_n, .syncIn_n, .syncOut_n,
      .resultShiftClk, .resultFrameStrobe, .sampleTick, .aligned, .syncCount);
   sync_ctrl_model partner_u (.sys_clk, .syncOut_n, .directSync_n, .startReq_n, .syncIn_n);
   always #5 sys_clk = ~sys_clk;
   // ********************************
   // behavioural model
   // ********************************
   always @(posedge sys_clk) begin
      cyc++;
      if (rst_n && syncIn_n === 1'h0) lastSync = cyc;
      if (rst_n && syncOut_n === 1'h0) begin
         `CHECK_EQ(expQ.size() > 0, 1'b1)
         // pop once: the compare macro evaluates its arguments twice
         if (expQ.size() > 0) begin
            expCyc = expQ.pop_front();
            `CHECK_EQ(cyc - expCyc, 5)
         end
      end
      // realignment restarts the frame, so only settled periods are measured
      if (rst_n && sampleTick === 1'h1) begin
         `CHECK_EQ(resultFrameStrobe, 1'b1)
         `CHECK_EQ(resultShiftClk, 1'b1)
         if (lastTick > 0 && aligned === 1'h1 && cyc - lastSync > 80)
            `CHECK_EQ(cyc - lastTick, int'(FRAME_LEN))
         lastTick = cyc;
      end
   end
   task automatic startReq(input int lowCyc, input int gap);
      expQ.push_back(cyc);
      syncSeen++;
      partner_u.request(lowCyc, $urandom_range(4000), gap);
   endtask
   task automatic checkState(input int waitCyc);
      repeat (waitCyc) @(negedge sys_clk);
      `CHECK_EQ(syncCount, 2'(syncSeen > 2 ? 2 : syncSeen))
      `CHECK_EQ(aligned, syncSeen >= 2)
      `CHECK_EQ(syncOut_n, 1'h1)
      `CHECK_EQ(expQ.size(), 0)
   endtask
   task automatic finalReport();
      if (errCount == 0 && nCompared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #200000;
      errCount++;
      finalReport();
   end
   initial begin
      sys_clk = 1'h0;
      rst_n = 1'h0;
      directSync_n = 1'h1;
      void'($urandom(84259));
      repeat (6) @(negedge sys_clk);
      rst_n = 1'h1;
      checkState(100);
      startReq(3, 12);
      checkState(20);
      startReq(3, 12);
      checkState(200);
      for (int i = 0; i < 8; i++) begin
         startReq(2 + $urandom_range(4), 10 + $urandom_range(10));
         checkState(5);
      end
      startReq(20, 12);
      checkState(20);
      directSync_n = 1'h0;
      @(negedge sys_clk);
      directSync_n = 1'h1;
      syncSeen++;
      checkState(20);
      rst_n = 1'h0;
      repeat (2) @(negedge sys_clk);
      rst_n = 1'h1;
      syncSeen = 0;
      checkState(3);
      startReq(4, 12);
      checkState(20);
      finalReport();
   end
endmodule
